// ==== src/pair_trig_ctrl.sv ====
// Trigger, pending and interrupt logic for converter pairs 10, 11 and 12.
// Assumes trigger inputs and conversion-done pulses are synchronous one-cycle events.
// Behaviour
// - Enabled pair raises interrupt request when its conversion completes; disabled raises none.
// - Pending flag sets on selected trigger, holds until conversion completes, then clears.
// - Writing one to soft trigger starts conversion only when selector one picks the pair's own software trigger bit.
// - Hardware clears the soft trigger bit when pending becomes set.
// - Selector zero disables conversion; no trigger starts it.
// - Selector one uses the pair's own software trigger bit.
// - Selector two uses the shared global software trigger.
// - Selector three uses the PWM special event trigger.
// - Selectors four to eleven pick PWM generator one to eight primary triggers.
// - Selector twelve uses timer one period match.
// - Selector thirteen uses the PWM secondary special event trigger.
// - Selectors fourteen to twenty-two pick generator one to nine secondary triggers.
// - Selectors twenty-three to thirty pick generator one to eight current-limit triggers.
// - Selector thirty-one uses timer two period match.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module pair_trig_ctrl
  import pair_trig_pkg::*;
#(
  parameter int PAIRS = pair_trig_pkg::NUM_PAIRS
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire pair_trig_pkg::trig_src_t trig_in,
  input wire logic [PAIRS-1:0] conv_done,
  output logic [PAIRS-1:0] conv_start,
  output logic [PAIRS-1:0] pair_irq,
  output logic irq
);
  import pair_trig_pkg::*;

  pair_ctrl_t ctrl_ff [PAIRS];
  pair_ctrl_t nxt_ctrl [PAIRS];
  logic [PAIRS-1:0] status_ff, nxt_status;
  logic [PAIRS-1:0] mask_ff, nxt_mask;
  logic [PAIRS-1:0] start_ff, nxt_start;
  logic [PAIRS-1:0] pirq_ff, nxt_pirq;
  logic irq_ff, nxt_irq;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [PAIRS-1:0] fire;
  logic [PAIRS-1:0] done_evt;
  logic global_sw;

  // Global software trigger is a write-only pulse
  assign global_sw = reg_wr && (reg_addr == ADDR_GLOBAL_SW) && reg_wdata[0];

  // Byte of the register port that holds pair p
  function automatic logic [7:0] pair_wbyte(input int p);
    logic [7:0] b;
    b = 8'h00;
    if (p < 2)
      b = (p == 0) ? reg_wdata[7:0] : reg_wdata[15:8];
    else
      b = reg_wdata[7:0];
    return b;
  endfunction : pair_wbyte

  function automatic logic pair_hit(input int p);
    logic h;
    h = 1'b0;
    if (p < 2)
      h = reg_wr && (reg_addr == ADDR_PAIR_10_11);
    else
      h = reg_wr && (reg_addr == ADDR_PAIR_12);
    return h;
  endfunction : pair_hit

  generate
    for (genvar p = 0; p < PAIRS; p++)
    begin : g_pair
      logic sel_trig;
      logic [7:0] wb;

      // Source mux
      always_comb
      begin
        sel_trig = 1'b0;
        if (ctrl_ff[p].sel == SEL_OFF)
          sel_trig = 1'b0;
        else if (ctrl_ff[p].sel == SEL_SW_OWN)
          sel_trig = ctrl_ff[p].swtrg;
        else if (ctrl_ff[p].sel == SEL_SW_GLOBAL)
          sel_trig = global_sw;
        else if (ctrl_ff[p].sel == SEL_PWM_SPECIAL)
          sel_trig = trig_in.special;
        else if (ctrl_ff[p].sel < SEL_TMR1)
          sel_trig = trig_in.pri_trig[3'(ctrl_ff[p].sel - SEL_PRI_FIRST)];
        else if (ctrl_ff[p].sel == SEL_TMR1)
          sel_trig = trig_in.tmr1_match;
        else if (ctrl_ff[p].sel == SEL_PWM_SEC_SPECIAL)
          sel_trig = trig_in.sec_special;
        else if (ctrl_ff[p].sel < SEL_CL_FIRST)
          sel_trig = trig_in.sec_trig[4'(ctrl_ff[p].sel - SEL_SEC_FIRST)];
        else if (ctrl_ff[p].sel < SEL_TMR2)
          sel_trig = trig_in.cl_trig[4'(ctrl_ff[p].sel - SEL_CL_FIRST)];
        else
          sel_trig = trig_in.tmr2_match;
      end

      // A trigger while pending is absorbed, except a set own soft trigger bit, which stays set and fires once pending clears
      assign fire[p] = sel_trig && !ctrl_ff[p].pend;
      assign done_evt[p] = conv_done[p] && ctrl_ff[p].pend;

      always_comb
      begin
        wb = pair_wbyte(p);
        nxt_ctrl[p] = ctrl_ff[p];
        if (pair_hit(p))
        begin
          nxt_ctrl[p].irq_en = wb[FLD_IRQ_EN];
          nxt_ctrl[p].sel = wb[FLD_SEL_LSB +: SEL_W];
          // Writing zero leaves a queued request alone
          if (wb[FLD_SWTRG])
            nxt_ctrl[p].swtrg = 1'b1;
        end
        if (done_evt[p])
          nxt_ctrl[p].pend = 1'b0;
        if (fire[p])
        begin
          nxt_ctrl[p].pend = 1'b1;
          nxt_ctrl[p].swtrg = 1'b0;
        end
        nxt_start[p] = fire[p];
        nxt_pirq[p] = done_evt[p] && ctrl_ff[p].irq_en;
        nxt_status[p] = status_ff[p];
        if (reg_wr && reg_addr == ADDR_IRQ_STATUS && reg_wdata[p])
          nxt_status[p] = 1'b0;
        // Set wins over a simultaneous clear
        if (done_evt[p] && ctrl_ff[p].irq_en)
          nxt_status[p] = 1'b1;
        nxt_mask[p] = mask_ff[p];
        if (reg_wr && reg_addr == ADDR_IRQ_MASK)
          nxt_mask[p] = reg_wdata[p];
      end

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ctrl_ff[p] <= pair_ctrl_t'(CTRL_RESET[7:0]);
          status_ff[p] <= 1'b0;
          mask_ff[p] <= 1'b0;
          start_ff[p] <= 1'b0;
          pirq_ff[p] <= 1'b0;
        end
        else
        begin
          ctrl_ff[p] <= nxt_ctrl[p];
          status_ff[p] <= nxt_status[p];
          mask_ff[p] <= nxt_mask[p];
          start_ff[p] <= nxt_start[p];
          pirq_ff[p] <= nxt_pirq[p];
        end
      end
    end
  endgenerate

  // Read mux and interrupt output
  always_comb
  begin
    nxt_rdata = 16'h0000;
    nxt_irq = |(nxt_status & nxt_mask);
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_PAIR_10_11: nxt_rdata = {ctrl_ff[1], ctrl_ff[0]};
        ADDR_PAIR_12: nxt_rdata = {8'h00, ctrl_ff[2]};
        ADDR_IRQ_STATUS: nxt_rdata = {13'h0, status_ff};
        ADDR_IRQ_MASK: nxt_rdata = {13'h0, mask_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign conv_start = start_ff;
  assign pair_irq = pirq_ff;
  assign irq = irq_ff;

  property p_pend_on_trig;
    @(posedge sys_clk) disable iff (!rst_n)
      fire[0] |=> ctrl_ff[0].pend && !ctrl_ff[0].swtrg && conv_start[0];
  endproperty
  a_pend_on_trig: assert property (p_pend_on_trig) else $error("pend not set on trigger");

  property p_pend_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      done_evt[1] && !fire[1] |=> !ctrl_ff[1].pend;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pend not cleared");

  property p_irq_enabled;
    @(posedge sys_clk) disable iff (!rst_n)
      done_evt[0] && ctrl_ff[0].irq_en |=> pair_irq[0] ##1 !pair_irq[0];
  endproperty
  a_irq_enabled: assert property (p_irq_enabled) else $error("missing pair irq");

  property p_irq_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
      !ctrl_ff[2].irq_en |=> !pair_irq[2];
  endproperty
  a_irq_disabled: assert property (p_irq_disabled) else $error("irq while disabled");

  property p_sel_off;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_OFF |=> !conv_start[0];
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("start while disabled");

  property p_sw_own;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[1].sel == SEL_SW_OWN && ctrl_ff[1].swtrg && !ctrl_ff[1].pend
        |=> conv_start[1] && !ctrl_ff[1].swtrg;
  endproperty
  a_sw_own: assert property (p_sw_own) else $error("own soft trigger ignored");

  property p_global;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[2].sel == SEL_SW_GLOBAL && global_sw && !ctrl_ff[2].pend |=> conv_start[2];
  endproperty
  a_global: assert property (p_global) else $error("global trigger ignored");

  property p_tmr2;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_TMR2 && trig_in.tmr2_match && !ctrl_ff[0].pend |=> conv_start[0];
  endproperty
  a_tmr2: assert property (p_tmr2) else $error("timer2 trigger ignored");

  property p_upper_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_PAIR_12 |=> reg_rdata[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_pend_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[2].pend && !done_evt[2] |=> ctrl_ff[2].pend;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pend dropped early");

  // Completion is two steps: done while enabled, then sticky flag plus pulse
  sequence s_done_enabled;
    done_evt[2] && ctrl_ff[2].irq_en;
  endsequence

  sequence s_flag_and_pulse;
    status_ff[2] && pair_irq[2];
  endsequence

  property p_status_set;
    @(posedge sys_clk) disable iff (!rst_n)
      s_done_enabled |=> s_flag_and_pulse;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!rst_n)
      irq == |(status_ff & mask_ff);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_sw_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_PAIR_10_11 && !reg_wdata[FLD_SWTRG] && !ctrl_ff[0].swtrg
        |=> !ctrl_ff[0].swtrg;
  endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("zero write queued trigger");

  property p_sw_kept;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].swtrg && !fire[0] |=> ctrl_ff[0].swtrg;
  endproperty
  a_sw_kept: assert property (p_sw_kept) else $error("soft trigger lost");

  property p_swtrg_clr;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(ctrl_ff[1].pend) |-> !ctrl_ff[1].swtrg;
  endproperty
  a_swtrg_clr: assert property (p_swtrg_clr) else $error("soft trigger not cleared");

  property p_special;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_PWM_SPECIAL && trig_in.special && !ctrl_ff[0].pend
        |=> conv_start[0];
  endproperty
  a_special: assert property (p_special) else $error("special trigger ignored");

  property p_pri_last;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_TMR1 - 5'h01 && trig_in.pri_trig[7] && !ctrl_ff[0].pend
        |=> conv_start[0];
  endproperty
  a_pri_last: assert property (p_pri_last) else $error("primary trigger ignored");

  property p_tmr1;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_TMR1 && trig_in.tmr1_match && !ctrl_ff[0].pend |=> conv_start[0];
  endproperty
  a_tmr1: assert property (p_tmr1) else $error("timer1 trigger ignored");

  property p_sec_special;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_PWM_SEC_SPECIAL && trig_in.sec_special && !ctrl_ff[0].pend
        |=> conv_start[0];
  endproperty
  a_sec_special: assert property (p_sec_special) else $error("sec special ignored");

  property p_sec_first;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_SEC_FIRST && trig_in.sec_trig[0] && !ctrl_ff[0].pend
        |=> conv_start[0];
  endproperty
  a_sec_first: assert property (p_sec_first) else $error("secondary trigger ignored");

  property p_sec_last;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_CL_FIRST - 5'h01 && trig_in.sec_trig[8] && !ctrl_ff[0].pend
        |=> conv_start[0];
  endproperty
  a_sec_last: assert property (p_sec_last) else $error("gen nine trigger ignored");

  property p_cl_last;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[0].sel == SEL_TMR2 - 5'h01 && trig_in.cl_trig[7] && !ctrl_ff[0].pend
        |=> conv_start[0];
  endproperty
  a_cl_last: assert property (p_cl_last) else $error("limit trigger ignored");

  property p_no_leak;
    @(posedge sys_clk) disable iff (!rst_n)
      fire[0] && !fire[1] && !fire[2]
        |=> conv_start[0] && !conv_start[1] && !conv_start[2];
  endproperty
  a_no_leak: assert property (p_no_leak) else $error("start leaked to other pair");
endmodule : pair_trig_ctrl

// ==== pkg/pair_trig_pkg.sv ====
// Package for the converter pair trigger control block.
// Assumes a 16-bit register port and one system clock.
package pair_trig_pkg;
  localparam int NUM_PAIRS = 3;
  localparam int SEL_W = 5;
  localparam int NUM_SRC = 32;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] ADDR_PAIR_10_11 = 4'h0;
  localparam logic [3:0] ADDR_PAIR_12 = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_GLOBAL_SW = 4'h4;
  // Field positions within one pair byte
  localparam int FLD_IRQ_EN = 7;
  localparam int FLD_PEND = 6;
  localparam int FLD_SWTRG = 5;
  localparam int FLD_SEL_LSB = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  // Selector encodings
  localparam logic [4:0] SEL_OFF = 5'h00;
  localparam logic [4:0] SEL_SW_OWN = 5'h01;
  localparam logic [4:0] SEL_SW_GLOBAL = 5'h02;
  localparam logic [4:0] SEL_PWM_SPECIAL = 5'h03;
  localparam logic [4:0] SEL_PRI_FIRST = 5'h04;
  localparam logic [4:0] SEL_TMR1 = 5'h0c;
  localparam logic [4:0] SEL_PWM_SEC_SPECIAL = 5'h0d;
  localparam logic [4:0] SEL_SEC_FIRST = 5'h0e;
  localparam logic [4:0] SEL_CL_FIRST = 5'h17;
  localparam logic [4:0] SEL_TMR2 = 5'h1f;

  typedef struct packed {
    logic [8:0] cl_trig;     // gen 9 unused, kept for width
    logic [8:0] sec_trig;
    logic [7:0] pri_trig;
    logic special;
    logic sec_special;
    logic tmr1_match;
    logic tmr2_match;
  } trig_src_t;

  typedef struct packed {
    logic irq_en;
    logic pend;
    logic swtrg;
    logic [4:0] sel;
  } pair_ctrl_t;
endpackage : pair_trig_pkg

// ==== bench/conv_core_model.sv ====
// Converter core model: answers each conversion start with a done pulse.
// Assumes one-cycle start pulses; the bench sets the answer lag.
`timescale 1ns/1ns
module conv_core_model
(
  input wire logic sys_clk,
  input wire logic [2:0] conv_start,
  input wire logic [3:0] lag,
  output logic [2:0] conv_done
);
  logic [3:0] cnt_ff [3];
  initial conv_done = '0;
  initial cnt_ff = '{default: '0};
  // A restart reloads the count, as a real core would abort and redo
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      conv_done[i] <= (cnt_ff[i] == 4'h1);
      if (conv_start[i])
        cnt_ff[i] <= lag;
      else if (cnt_ff[i] != 4'h0)
        cnt_ff[i] <= cnt_ff[i] - 4'h1;
    end
  end
endmodule : conv_core_model

// ==== bench/adc_pair_trigger_control_tb_top.sv ====
// Bench for the pair trigger control block.
// Assumes the converter core model answers every start.
`timescale 1ns/1ns
module adc_pair_trigger_control_tb_top;
  import pair_trig_pkg::*;
  typedef struct {logic [4:0] sel; logic exp;} row_t;
  row_t rows [32];
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  trig_src_t trig_in = '0;
  logic [2:0] conv_done;
  logic [2:0] conv_start;
  logic [2:0] pair_irq;
  logic irq;
  logic [3:0] lag = 4'h2;
  int err_count = 0;
  int num_checks = 0;
  always #4 sys_clk = ~sys_clk;
  pair_trig_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_in(trig_in), .conv_done(conv_done), .conv_start(conv_start),
    .pair_irq(pair_irq), .irq(irq));
  conv_core_model i_core (.sys_clk(sys_clk), .conv_start(conv_start), .lag(lag),
    .conv_done(conv_done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic pulse(input trig_src_t t);
    @(posedge sys_clk);
    trig_in <= t;
    @(posedge sys_clk);
    trig_in <= '0;
  endtask : pulse
  // Bounded so a missing pulse fails instead of hanging
  task automatic see(input logic irq_side, input logic [2:0] m);
    logic [2:0] s;
    s = '0;
    for (int i = 0; i < 6; i++)
    begin
      #1 s = irq_side ? pair_irq : conv_start;
      if (s != 3'h0)
        break;
      @(posedge sys_clk);
    end
    chk(16'(s), 16'(m));
  endtask : see
  function automatic trig_src_t src_for(input logic [4:0] s);
    trig_src_t t;
    t = '0;
    case (s) inside
      SEL_PWM_SPECIAL: t.special = 1'b1;
      SEL_TMR1: t.tmr1_match = 1'b1;
      SEL_PWM_SEC_SPECIAL: t.sec_special = 1'b1;
      SEL_TMR2: t.tmr2_match = 1'b1;
      [5'h04:5'h0b]: t.pri_trig[s - SEL_PRI_FIRST] = 1'b1;
      [5'h0e:5'h16]: t.sec_trig[s - SEL_SEC_FIRST] = 1'b1;
      [5'h17:5'h1e]: t.cl_trig[s - SEL_CL_FIRST] = 1'b1;
      default: t = '0;
    endcase
    return t;
  endfunction : src_for
  task automatic close_out();
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
  initial
  begin
    for (int i = 0; i < 32; i++)
      rows[i] = '{sel: 5'(i), exp: (i >= 3)};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++)
    begin
      rd(4'(a));
      chk(rd_val, CTRL_RESET);
    end
    foreach (rows[i])
    begin
      wr(ADDR_PAIR_10_11, {11'h000, rows[i].sel});
      pulse(~src_for(rows[i].sel));
      see(1'b0, 3'h0);
      pulse(src_for(rows[i].sel));
      see(1'b0, {2'b00, rows[i].exp});
      repeat (6) @(posedge sys_clk);
    end
    lag <= 4'ha;
    wr(ADDR_PAIR_10_11, 16'h0001);
    see(1'b0, 3'h0);
    wr(ADDR_PAIR_10_11, 16'h0021);
    see(1'b0, 3'h1);
    rd(ADDR_PAIR_10_11);
    chk(rd_val, 16'h0041);
    repeat (12) @(posedge sys_clk);
    rd(ADDR_PAIR_10_11);
    chk(rd_val, 16'h0001);
    wr(ADDR_PAIR_10_11, 16'h0003);
    pulse(src_for(SEL_PWM_SPECIAL));
    see(1'b0, 3'h1);
    pulse(src_for(SEL_PWM_SPECIAL));
    see(1'b0, 3'h0);
    repeat (12) @(posedge sys_clk);
    lag <= 4'h2;
    wr(ADDR_IRQ_MASK, 16'h0004);
    wr(ADDR_PAIR_10_11, 16'h0202);
    wr(ADDR_PAIR_12, 16'hff82);
    rd(ADDR_PAIR_12);
    chk(rd_val, 16'h0082);
    wr(ADDR_GLOBAL_SW, 16'h0001);
    see(1'b0, 3'h7);
    @(posedge sys_clk);
    see(1'b1, 3'h4);
    repeat (2) @(posedge sys_clk);
    #1 chk(16'(irq), 16'h0001);
    rd(ADDR_IRQ_STATUS);
    chk(rd_val, 16'h0004);
    wr(ADDR_IRQ_STATUS, 16'h0004);
    repeat (2) @(posedge sys_clk);
    #1 chk(16'(irq), 16'h0000);
    wr(ADDR_PAIR_10_11, 16'h0023);
    see(1'b0, 3'h0);
    rd(ADDR_PAIR_10_11);
    chk(rd_val, 16'h0023);
    wr(ADDR_PAIR_10_11, 16'h2181);
    see(1'b0, 3'h3);
    see(1'b1, 3'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk(16'(irq), 16'h0000);
    rd(ADDR_IRQ_STATUS);
    chk(rd_val, 16'h0001);
    wr(ADDR_PAIR_10_11, 16'h0003);
    pulse(src_for(SEL_PWM_SPECIAL));
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk(16'(conv_start), 16'h0000);
    rd(ADDR_PAIR_10_11);
    chk(rd_val, CTRL_RESET);
    rd(ADDR_IRQ_STATUS);
    chk(rd_val, 16'h0000);
    close_out();
  end
endmodule : adc_pair_trigger_control_tb_top
